// ===== core/pos_params.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * positioning sequencer. assumes a 200 mhz unit clock and a byte-addressed
 * classic wishbone slave with 32-bit data.
 */
`ifndef POS_PARAMS_SVH
`define POS_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFS_COMMAND   8'h00
`define OFS_CONTROL   8'h04
`define OFS_OPERAND   8'h08
`define OFS_TARGET_X  8'h0c
`define OFS_TARGET_Y  8'h10
`define OFS_SPEED     8'h14
`define OFS_TIMEOUT   8'h18
`define OFS_DROOP     8'h1c
`define OFS_STATUS    8'h20
`define OFS_ORIGIN_X  8'h24
`define OFS_ORIGIN_Y  8'h28

// ----------------------------------------------------------------------
// command codes (written to the command register)
// ----------------------------------------------------------------------
`define CMD_DWELL     3'h1
`define CMD_CHECK     3'h2
`define CMD_HOME      3'h3
`define CMD_CAPTURE   3'h4
`define CMD_GO_ORIGIN 3'h5
`define CMD_MOVE      3'h6
`define CMD_ABORT_MV  3'h7

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTL_X_INHIBIT    0
`define CTL_Y_INHIBIT    1
`define CTL_ABORT_SEL    2
`define CTL_TWO_AXIS     3
`define CTL_LEGACY_FW    4
`define CTL_CHECK_AFTER  5
`define CTL_PROG_LSB     8
`define CTL_PROG_MSB     14
`define CTL_WIDTH        15
`define PROG_MAX         7'h63

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STS_BUSY       0
`define STS_X_HOME     1
`define STS_Y_HOME     2
`define STS_POS_ERR    3
`define STS_ABORTED    4
`define STS_REJECT     5
`define STS_STATE_LSB  8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_CONTROL  15'h0000
`define RST_TIMEOUT  16'h0000
`define RST_DROOP    32'h0000_0000

// ----------------------------------------------------------------------
// timing: dwell and timeout tick of 10 ms at a 5 ns clock
// ----------------------------------------------------------------------
`define TICK_TIME_NS   10000000
`define CLK_PERIOD_NS  5
`define TICK_CYCLES    (`TICK_TIME_NS / `CLK_PERIOD_NS)

`endif

// ===== core/pos_pkg.sv
/*
 * types of the positioning sequencer: state encoding, pulse generator request and the
 * whole state record. assumes pos_params.svh for the numbers.
 */
package pos_pkg;

    // one-hot sequencer states
    typedef enum logic [7:0] {
        S_IDLE   = 8'h01,
        S_DWELL  = 8'h02,
        S_MREQ   = 8'h04,
        S_MRUN   = 8'h08,
        S_SETTLE = 8'h10,
        S_HREQ   = 8'h20,
        S_HRUN   = 8'h40,
        S_DECEL  = 8'h80
    } seq_state_t;

    // request to the pulse generator
    typedef struct packed {
        logic        move_req;
        logic        home_req;
        logic [1:0]  home_axes;
        logic        use_max_speed;
        logic        blend;
        logic        decel_stop;
        logic [31:0] target_x;
        logic [31:0] target_y;
        logic [31:0] speed;
    } motion_cmd_t;

    // whole module state
    typedef struct packed {
        seq_state_t  st;
        logic [14:0] ctrl;
        logic [15:0] operand;
        logic [31:0] tgt_x;
        logic [31:0] tgt_y;
        logic [31:0] speed;
        logic [15:0] timeout;
        logic [31:0] droop_lim;
        logic [31:0] origin_x;
        logic [31:0] origin_y;
        logic [1:0]  home_done;
        logic        pos_err;
        logic        aborted;
        logic        reject;
        logic        ack;
        logic [31:0] dat;
        logic [31:0] div;
        logic [15:0] ticks;
        logic [2:0]  abort_s1;
        logic [2:0]  abort_s2;
        logic [1:0]  amp_s1;
        logic [1:0]  amp_s2;
        logic [1:0]  abort_pick;
        logic        abort_mode;
        logic        check_after;
        logic        checking;
        logic        busy_seen;
        motion_cmd_t mc;
    } pos_state_t;

endpackage

// ===== core/positioning_dwell_zero_abort.sv
/*
 * positioning_dwell_zero_abort: instruction sequencer for dwell, servo
 * settle check, machine home return, electrical origin capture and return,
 * and the abort-on-input move.
 * assumes an external pulse generator that takes one request at a time,
 * raises move_busy_i while it outputs pulses and lowers it when done, and
 * that reports the amplifier droop and the present position.
 */

// register map, field positions and tick counts
`include "pos_params.svh"

module positioning_dwell_zero_abort
    import pos_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES  // cycles per 10 ms tick
) (
    input  wire logic        clk_i,                    // unit clock, 200 mhz
    input  wire logic        rst_i,                    // synchronous reset, high
    // wishbone classic slave
    input  wire logic        cyc_i,                    // bus cycle
    input  wire logic        stb_i,                    // strobe
    input  wire logic        we_i,                     // write enable
    input  wire logic [7:0]  adr_i,                    // byte address
    input  wire logic [3:0]  sel_i,                    // byte lanes
    input  wire logic [31:0] dat_i,                    // write data
    output logic      [31:0] dat_o,                    // read data
    output logic             ack_o,                    // cycle acknowledge
    // pulse generator side
    input  wire logic        move_busy_i,              // pulse output active
    input  wire logic [31:0] droop_i,                  // pulses held in amplifier
    input  wire logic [31:0] present_x_i,              // present position x
    input  wire logic [31:0] present_y_i,              // present position y
    output logic             move_req_o,               // move request
    output logic             home_req_o,               // home return request
    output logic      [1:0]  home_axes_o,              // axes taking part
    output logic             use_max_speed_o,          // max speed, param ramps
    output logic             blend_o,                  // keep moving at end
    output logic             decel_stop_o,             // decelerate and stop
    output logic      [31:0] target_x_o,               // target x
    output logic      [31:0] target_y_o,               // target y
    output logic      [31:0] speed_o,                  // vector speed
    // amplifier and external inputs
    input  wire logic [1:0]  amp_position_done_i,      // per-axis completion
    input  wire logic        abort_input_default_i,    // single-axis default
    input  wire logic        abort_input_alt_i,        // single-axis alternate
    input  wire logic        two_axis_abort_input_i,   // two-axis fixed input
    // status
    output logic      [1:0]  home_done_o,              // y, x home done flags
    output logic             pos_error_o,              // positioning error
    output logic             busy_o                    // instruction running
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------

    // merge write data into a word by byte lanes
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] nw,
                                               input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // pick the synchronised abort level for the latched input choice
    function automatic logic abort_level(input logic [1:0] pick,
                                         input logic [2:0] lvl);
        logic r;
        r = 1'b0;
        case (pick)
            2'h0:    r = lvl[0];
            2'h1:    r = lvl[1];
            2'h2:    r = lvl[2];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    pos_state_t  q;
    pos_state_t  d;
    logic        bus_go;
    logic        bus_wr;
    logic        tick;
    logic        abort_now;
    logic [1:0]  home_sel;
    logic [2:0]  cmd;
    logic [31:0] wsel;
    logic [31:0] ctrl_w;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------

    // bus decode and the free tick
    assign bus_go    = cyc_i & stb_i & ~q.ack;
    assign bus_wr    = bus_go & we_i;
    assign tick      = (q.div == TICK_LAST);
    assign abort_now = abort_level(q.abort_pick, q.abort_s2);
    assign home_sel  = ~q.ctrl[`CTL_Y_INHIBIT:`CTL_X_INHIBIT];
    assign cmd       = dat_i[2:0];
    assign ctrl_w    = lane_merge({17'h0, q.ctrl}, dat_i, sel_i);
    assign wsel      = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

    always_comb begin
        d = q;

        // two-stage synchronisers; first stage feeds only the second
        d.abort_s1 = {two_axis_abort_input_i, abort_input_alt_i, abort_input_default_i};
        d.abort_s2 = q.abort_s1;
        d.amp_s1   = amp_position_done_i;
        d.amp_s2   = q.amp_s1;

        // tick divider, restarted when an instruction starts
        d.div = tick ? 32'h0000_0000 : q.div + 32'h0000_0001;

        // request strobes last one cycle unless held below
        d.mc.move_req = 1'b0;
        d.mc.home_req = 1'b0;

        // bus answer: one registered ack per request, a cycle after the strobe, dropped next cycle
        d.ack = bus_go;
        d.dat = 32'h0000_0000;
        if (bus_go && !we_i) begin
            case (adr_i)
                `OFS_CONTROL:  d.dat = {17'h0, q.ctrl};
                `OFS_OPERAND:  d.dat = {16'h0, q.operand};
                `OFS_TARGET_X: d.dat = q.tgt_x;
                `OFS_TARGET_Y: d.dat = q.tgt_y;
                `OFS_SPEED:    d.dat = q.speed;
                `OFS_TIMEOUT:  d.dat = {16'h0, q.timeout};
                `OFS_DROOP:    d.dat = q.droop_lim;
                `OFS_STATUS:   d.dat = {16'h0, q.st, 2'h0, q.reject, q.aborted, q.pos_err,
                                        q.home_done, (q.st != S_IDLE)};
                `OFS_ORIGIN_X: d.dat = q.origin_x;
                `OFS_ORIGIN_Y: d.dat = q.origin_y;
                default:       d.dat = 32'h0000_0000;
            endcase
        end

        // register writes; unmapped addresses are acked and ignored
        if (bus_wr) begin
            case (adr_i)
                `OFS_CONTROL:  d.ctrl      = ctrl_w[14:0];
                `OFS_OPERAND:  d.operand   = 16'(lane_merge({16'h0, q.operand}, dat_i, sel_i));
                `OFS_TARGET_X: d.tgt_x     = lane_merge(q.tgt_x, dat_i, sel_i);
                `OFS_TARGET_Y: d.tgt_y     = lane_merge(q.tgt_y, dat_i, sel_i);
                `OFS_SPEED:    d.speed     = lane_merge(q.speed, dat_i, sel_i);
                `OFS_TIMEOUT:  d.timeout   = 16'(lane_merge({16'h0, q.timeout}, dat_i, sel_i));
                `OFS_DROOP:    d.droop_lim = lane_merge(q.droop_lim, dat_i, sel_i);
                `OFS_STATUS: begin
                    // write one to clear; a same-cycle set below still wins
                    if (wsel[`STS_POS_ERR] && dat_i[`STS_POS_ERR]) d.pos_err = 1'b0;
                    if (wsel[`STS_ABORTED] && dat_i[`STS_ABORTED]) d.aborted = 1'b0;
                    if (wsel[`STS_REJECT]  && dat_i[`STS_REJECT])  d.reject  = 1'b0;
                end
                default: ;
            endcase
        end

        // sequencer
        case (q.st)
            S_IDLE: begin
                if (bus_wr && adr_i == `OFS_COMMAND && sel_i[0]) begin
                    d.div   = 32'h0000_0000;
                    d.ticks = 16'h0000;
                    case (cmd)
                        `CMD_DWELL: begin
                            d.st = S_DWELL;
                        end
                        `CMD_CHECK: begin
                            d.st       = S_SETTLE;
                            d.checking = 1'b0;
                        end
                        `CMD_HOME: begin
                            // nothing selected: finish without motion
                            if (home_sel != 2'b00) begin
                                d.mc.home_axes = home_sel;
                                d.st           = S_HREQ;
                            end
                        end
                        `CMD_CAPTURE: begin
                            d.origin_x = present_x_i;
                            d.origin_y = present_y_i;
                        end
                        `CMD_GO_ORIGIN: begin
                            d.mc.target_x      = q.origin_x;
                            d.mc.target_y      = q.origin_y;
                            d.mc.use_max_speed = 1'b1;
                            d.mc.blend         = 1'b0;
                            d.check_after      = 1'b1;
                            d.abort_mode       = 1'b0;
                            d.st               = S_MREQ;
                        end
                        `CMD_MOVE, `CMD_ABORT_MV: begin
                            d.mc.target_x      = q.tgt_x;
                            d.mc.target_y      = q.tgt_y;
                            d.mc.speed         = q.speed;
                            d.mc.use_max_speed = 1'b0;
                            d.check_after      = q.ctrl[`CTL_CHECK_AFTER];
                            d.mc.blend         = ~q.ctrl[`CTL_CHECK_AFTER] & (cmd == `CMD_MOVE);
                            d.abort_mode       = (cmd == `CMD_ABORT_MV);
                            d.st               = S_MREQ;
                            // input choice is frozen here for the whole move
                            if (q.ctrl[`CTL_TWO_AXIS]) begin
                                d.abort_pick = 2'h2;
                            end else if (q.ctrl[`CTL_ABORT_SEL] && !q.ctrl[`CTL_LEGACY_FW]) begin
                                d.abort_pick = 2'h1;
                            end else begin
                                d.abort_pick = 2'h0;
                            end
                            // two-axis abort move only in programs 0..99
                            if (cmd == `CMD_ABORT_MV && q.ctrl[`CTL_TWO_AXIS] &&
                                q.ctrl[`CTL_PROG_MSB:`CTL_PROG_LSB] > `PROG_MAX) begin
                                d.reject = 1'b1;
                                d.st     = S_IDLE;
                            end
                        end
                        default: begin
                            d.reject = 1'b1;
                        end
                    endcase
                end else if (bus_wr && adr_i == `OFS_COMMAND) begin
                    d.reject = 1'b1;
                end
            end

            S_DWELL: begin
                // operand ticks of 10 ms; operand zero ends at once
                if (q.ticks >= q.operand) begin
                    d.st = S_IDLE;
                end else if (tick) begin
                    d.ticks = q.ticks + 16'h0001;
                end
            end

            S_MREQ: begin
                // hold the request until the generator shows busy
                d.mc.move_req = ~move_busy_i;
                if (move_busy_i) begin
                    d.st = S_MRUN;
                end
            end

            S_MRUN: begin
                if (q.abort_mode && abort_now) begin
                    d.mc.decel_stop = 1'b1;
                    d.st            = S_DECEL;
                end else if (!move_busy_i) begin
                    // reached target; no abort seen
                    d.div   = 32'h0000_0000;
                    d.ticks = 16'h0000;
                    d.st    = q.check_after ? S_SETTLE : S_IDLE;
                    d.checking = 1'b0;
                end
            end

            S_DECEL: begin
                // remaining distance is dropped; go on once stopped
                if (!move_busy_i) begin
                    d.mc.decel_stop = 1'b0;
                    d.aborted       = 1'b1;
                    d.st            = S_IDLE;
                end
            end

            S_SETTLE: begin
                if (q.timeout == 16'h0000) begin
                    d.st = S_IDLE;
                end else begin
                    if (tick) begin
                        d.ticks = q.ticks + 16'h0001;
                    end
                    if (droop_i <= q.droop_lim) begin
                        d.checking = 1'b1;
                    end
                    if (q.checking && (&q.amp_s2)) begin
                        d.st = S_IDLE;
                    end else if (q.ticks > q.timeout) begin
                        d.pos_err = 1'b1;
                        d.st      = S_IDLE;
                    end
                end
            end

            S_HREQ: begin
                d.mc.home_req = ~move_busy_i;
                if (move_busy_i) begin
                    d.st = S_HRUN;
                end
            end

            S_HRUN: begin
                if (!move_busy_i) begin
                    // only axes that took part are flagged
                    d.home_done = q.home_done | q.mc.home_axes;
                    d.st        = S_IDLE;
                end
            end

            default: begin
                d.st = S_IDLE;
            end
        endcase

        // busy kept in its own flop so the busy output needs no decode
        d.busy_seen = (d.st != S_IDLE);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------

    // home flags are cleared by reset alone, never by software
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q           <= '0;
            q.st        <= S_IDLE;
            q.ctrl      <= `RST_CONTROL;
            q.timeout   <= `RST_TIMEOUT;
            q.droop_lim <= `RST_DROOP;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign dat_o           = q.dat;
    assign ack_o           = q.ack;
    assign move_req_o      = q.mc.move_req;
    assign home_req_o      = q.mc.home_req;
    assign home_axes_o     = q.mc.home_axes;
    assign use_max_speed_o = q.mc.use_max_speed;
    assign blend_o         = q.mc.blend;
    assign decel_stop_o    = q.mc.decel_stop;
    assign target_x_o      = q.mc.target_x;
    assign target_y_o      = q.mc.target_y;
    assign speed_o         = q.mc.speed;
    assign home_done_o     = q.home_done;
    assign pos_error_o     = q.pos_err;
    assign busy_o          = q.busy_seen;

endmodule // positioning_dwell_zero_abort

// ===== tb/amp_model.sv
/* pulse generator and servo amplifier model.
   assumes the request is held until busy is seen. */
module amp_model #(parameter int RUN = 40) (
    input  wire logic       clk_i,  // unit clock
    input  wire logic       req_i,  // move or home request
    input  wire logic       stop_i, // decelerate and stop
    output logic            busy_o = 1'b0,  // pulses running
    output logic      [1:0] done_o = 2'b11  // amplifier completion
);
    timeunit 1ns / 1ps;
    int cnt = 0;
    // slow pickup of three cycles; a stop cuts the run short
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        done_o <= {2{!busy_o}}; // completion only once pulses end
        if (!busy_o && !req_i) cnt <= 0;
        if (!busy_o && req_i && cnt == 3) busy_o <= 1'b1;
        if (busy_o && (cnt > RUN || (stop_i && cnt > 8))) begin
            busy_o <= 1'b0;
            cnt <= 0;
        end
    end
endmodule // amp_model

// ===== tb/pos_chk_assertions.sv
/* port checker of the positioning sequencer, bound from the bench top.
   assumes one clock and a synchronous, active-high reset. */
module pos_chk (
    input wire logic        clk_i, rst_i, cyc_i, stb_i, ack_o, busy_o,    // clock, reset, bus
    input wire logic        move_busy_i, move_req_o, home_req_o, decel_stop_o, // motion link
    input wire logic [1:0]  home_axes_o, home_done_o,                   // home axes and flags
    input wire logic [31:0] dat_o                                       // read data
);
    timeunit 1ns / 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a taken request, then the one-cycle answer
    sequence bus_take; cyc_i && stb_i && !ack_o; endsequence
    sequence ack_pulse; ack_o ##1 !ack_o; endsequence
    ack_once_a: assert property (bus_take |=> ack_pulse) else $error("ack not one pulse");
    dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    home_keep_a: assert property (|home_done_o |=> (home_done_o & $past(home_done_o)) == $past(home_done_o))
        else $error("home flag dropped");
    home_axes_a: assert property (home_req_o |-> home_axes_o != 2'b00)
        else $error("home request with no axis");
    req_drop_a: assert property ((move_req_o || home_req_o) && move_busy_i |=> !move_req_o && !home_req_o)
        else $error("request held after pickup");
    req_busy_a: assert property (move_req_o || home_req_o |-> busy_o) else $error("request while idle");
    decel_hold_a: assert property (decel_stop_o && move_busy_i |=> decel_stop_o)
        else $error("stop dropped while moving");
    decel_end_a: assert property (decel_stop_o && !move_busy_i |-> ##[1:2] !decel_stop_o)
        else $error("stop held after halt");
endmodule // pos_chk

// ===== tb/tb_positioning_dwell_zero_abort.sv
/* bench of positioning_dwell_zero_abort: wishbone master, read notes
   queued and compared on ack. assumes amp_model as the far side. */
`include "pos_params.svh"
module tb_positioning_dwell_zero_abort;
    timeunit 1ns / 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, two_axis_abort_input_i = 1'b0;
    logic abort_input_default_i = 1'b0, abort_input_alt_i = 1'b0, ack_o, busy_o, pos_error_o, move_busy_i;
    logic move_req_o, home_req_o, use_max_speed_o, blend_o, decel_stop_o;
    logic [1:0]  amp_position_done_i, home_axes_o, home_done_o;
    logic [3:0]  sel_i = 4'hf;
    logic [7:0]  adr_i = 8'h00;
    logic [31:0] dat_i = '0, droop_i = '0, present_x_i = '0, present_y_i = '0, rnd = 32'hcb7d;
    logic [31:0] dat_o, target_x_o, target_y_o, speed_o, org;
    logic [32:0] q[$];
    logic [32:0] note;
    int n_errors = 0, compares = 0;
    positioning_dwell_zero_abort #(.TICK_CYCLES(20)) positioning_dwell_zero_abort_i (.clk_i, .rst_i, .cyc_i,
        .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .move_busy_i, .droop_i, .present_x_i, .present_y_i,
        .move_req_o, .home_req_o, .home_axes_o, .use_max_speed_o, .blend_o, .decel_stop_o, .target_x_o,
        .target_y_o, .speed_o, .amp_position_done_i, .abort_input_default_i, .abort_input_alt_i,
        .two_axis_abort_input_i, .home_done_o, .pos_error_o, .busy_o);
    amp_model amp_model_i (.clk_i, .req_i(move_req_o | home_req_o), .stop_i(decel_stop_o),
        .busy_o(move_busy_i), .done_o(amp_position_done_i));
    always #2.5 clk_i = ~clk_i;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    // reads carry their expected word in d; held until ack is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        q.push_back({!w, d});
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic cmd(input logic [2:0] c);
        bus(1'b1, `OFS_COMMAND, {29'h0, c});
    endtask
    task automatic idle();
        repeat (400) if (busy_o !== 1'b0) @(posedge clk_i);
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // oldest note against each answer
    always @(posedge clk_i) if (ack_o === 1'b1) begin
        note = q.pop_front();
        if (note[32]) check(dat_o, note[31:0]);
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, `OFS_TIMEOUT, 32'h0);
        bus(1'b0, 8'h3c, 32'h0);
        bus(1'b1, `OFS_CONTROL, 32'h3);
        cmd(`CMD_HOME);
        bus(1'b0, `OFS_STATUS, 32'h0100);
        bus(1'b1, `OFS_CONTROL, 32'h2);
        cmd(`CMD_HOME);
        idle();
        bus(1'b0, `OFS_STATUS, 32'h0102);
        bus(1'b1, `OFS_CONTROL, 32'h0);
        cmd(`CMD_HOME);
        idle();
        bus(1'b0, `OFS_STATUS, 32'h0106);
        bus(1'b1, `OFS_OPERAND, 32'h3);
        cmd(`CMD_DWELL);
        repeat (50) @(posedge clk_i);
        check({31'h0, busy_o}, 32'h1);
        repeat (15) @(posedge clk_i);
        check({31'h0, busy_o}, 32'h0);
        rnd = xs(rnd);
        org = rnd;
        present_x_i <= rnd;
        present_y_i <= ~rnd;
        cmd(`CMD_CAPTURE);
        bus(1'b0, `OFS_ORIGIN_X, rnd);
        // default, alternate, legacy-forced default, then no abort at all
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `OFS_CONTROL, (i == 1) ? 32'h4 : (i == 2) ? 32'h14 : 32'h0);
            rnd = xs(rnd);
            bus(1'b1, `OFS_TARGET_X, rnd);
            cmd(`CMD_ABORT_MV);
            repeat (3) @(posedge clk_i);
            abort_input_default_i <= (i == 0 || i == 2);
            abort_input_alt_i <= (i == 1);
            idle();
            abort_input_default_i <= 1'b0;
            abort_input_alt_i <= 1'b0;
            bus(1'b0, `OFS_STATUS, (i == 3) ? 32'h0106 : 32'h0116);
            check(target_x_o, rnd);
            bus(1'b1, `OFS_STATUS, 32'h38);
        end
        // plain move with no check after it blends on
        bus(1'b1, `OFS_SPEED, rnd);
        cmd(`CMD_MOVE);
        check({30'h0, blend_o, use_max_speed_o}, 32'h2);
        check(speed_o, rnd);
        idle();
        // zero timeout skips the check; droop over limit then times out
        droop_i <= 32'h5;
        cmd(`CMD_CHECK);
        idle();
        check({31'h0, pos_error_o}, 32'h0);
        bus(1'b1, `OFS_TIMEOUT, 32'h2);
        cmd(`CMD_CHECK);
        idle();
        check({31'h0, pos_error_o}, 32'h1);
        bus(1'b1, `OFS_STATUS, 32'h38);
        droop_i <= 32'h0;
        cmd(`CMD_GO_ORIGIN);
        check({30'h0, blend_o, use_max_speed_o}, 32'h1);
        check(target_x_o, org);
        check(target_y_o, ~org);
        idle();
        bus(1'b0, `OFS_STATUS, 32'h0106);
        // two-axis abort move: program over 99 refused, fixed input stops it
        bus(1'b1, `OFS_CONTROL, 32'h6408);
        cmd(`CMD_ABORT_MV);
        bus(1'b0, `OFS_STATUS, 32'h0126);
        bus(1'b1, `OFS_CONTROL, 32'h8);
        two_axis_abort_input_i <= 1'b1;
        cmd(`CMD_ABORT_MV);
        idle();
        two_axis_abort_input_i <= 1'b0;
        bus(1'b0, `OFS_STATUS, 32'h0136);
        check({30'h0, home_done_o}, 32'h3);
        close_out();
    end
endmodule // tb_positioning_dwell_zero_abort
bind positioning_dwell_zero_abort pos_chk pos_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .busy_o,
    .move_busy_i, .move_req_o, .home_req_o, .decel_stop_o, .home_axes_o, .home_done_o, .dat_o);
